// [core/cold_load_defs.vh]
`ifndef COLD_LOAD_DEFS_VH
`define COLD_LOAD_DEFS_VH

// ----------------------------------------------------------------
// Detection mode encodings
// ----------------------------------------------------------------
`define MODE_W 2
`define MODE_POSITION 2'h0
`define MODE_UNDERCURRENT 2'h1
`define MODE_POS_AND_UC 2'h2
`define MODE_POS_OR_UC 2'h3

// ----------------------------------------------------------------
// Widths and fixed values
// ----------------------------------------------------------------
`define CUR_W 16
`define TMR_W 32
`define TMR_ZERO 32'h00000000
`define TMR_ONE 32'h00000001
`define CUR_ZERO 16'h0000
`define RATIO_NUM 20'h00009
`define RATIO_DEN 20'h0000a

`endif

// [core/cold_load_pickup_detector.v]
`timescale 1ns/10ps
`include "cold_load_defs.vh"

// ----------------------------------------------------------------
// Delay counter
// ----------------------------------------------------------------
module delay_counter (
    input wire clk,
    input wire rst,
    input wire start,
    input wire stop,
    input wire [`TMR_W-1:0] preset,
    output reg running,
    output reg done
);
    reg [`TMR_W-1:0] count;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= `TMR_ZERO;
            running <= 1'h0;
            done <= 1'h0;
        end else if (stop) begin
            count <= `TMR_ZERO;
            running <= 1'h0;
            done <= 1'h0;
        end else if (start) begin
            count <= preset;
            running <= 1'h1;
            done <= 1'h0;
        end else if (running) begin
            if (count <= `TMR_ONE) begin
                running <= 1'h0;
                done <= 1'h1;
            end else begin
                count <= count - `TMR_ONE;
            end
        end else begin
            done <= 1'h0;
        end
    end
endmodule

// ----------------------------------------------------------------
// Cold load supervisor
// ----------------------------------------------------------------
module cold_load_pickup_detector (
    input wire clk,
    input wire rst,
    input wire [`MODE_W-1:0] detectMode,
    input wire breakerOpen,
    input wire underCurrent,
    input wire [`CUR_W-1:0] loadCurrent,
    input wire [`CUR_W-1:0] inrushThreshold,
    input wire [`TMR_W-1:0] loadOffPreset,
    input wire [`TMR_W-1:0] settlePreset,
    input wire [`TMR_W-1:0] maxBlockPreset,
    input wire externalBlock,
    input wire internalBlock,
    input wire blockSelect,
    input wire auto_reclose_running,
    output reg cold_load_enable,
    output reg inrushPresent,
    output reg [4:0] stateOut
);
    localparam [4:0] ST_WARM = 5'h01;
    localparam [4:0] ST_LOADOFF = 5'h02;
    localparam [4:0] ST_COLD = 5'h04;
    localparam [4:0] ST_INRUSH = 5'h08;
    localparam [4:0] ST_HOLD = 5'h10;

    reg [4:0] state;
    reg [4:0] next_state;
    reg isCold;
    reg blockSource;
    reg blocked;
    reg startLoadOff;
    reg startSettle;
    reg stopSettle;
    reg startMax;
    reg settleSeen;
    reg next_settleSeen;
    reg next_enable;
    reg next_inrush;
    wire loadOffDone;
    wire settleDone;
    wire maxDone;
    wire loadOffStop;
    wire settleStop;
    wire maxStop;
    wire holdRelease;
    wire [`CUR_W+3:0] curScaled;
    wire [`CUR_W+3:0] thrScaled;
    wire aboveThr;
    wire belowRelease;
    wire inWatch;

    // ------------------------------------------------------------
    // Current comparison
    // ------------------------------------------------------------
    assign curScaled = {4'h0, loadCurrent} * `RATIO_DEN;
    assign thrScaled = {4'h0, inrushThreshold} * `RATIO_NUM;
    assign aboveThr = loadCurrent > inrushThreshold;
    assign belowRelease = curScaled <= thrScaled;
    assign inWatch = (state == ST_INRUSH) || (state == ST_HOLD);

    // ------------------------------------------------------------
    // Cold test
    // ------------------------------------------------------------
    always @* begin
        case (detectMode)
            `MODE_POSITION: isCold = breakerOpen;
            `MODE_UNDERCURRENT: isCold = underCurrent;
            `MODE_POS_AND_UC: isCold = breakerOpen & underCurrent;
            default: isCold = breakerOpen | underCurrent;
        endcase
    end

    // ------------------------------------------------------------
    // Block selection
    // ------------------------------------------------------------
    always @* begin
        if (blockSelect) begin
            blockSource = externalBlock;
        end else begin
            blockSource = internalBlock;
        end
        blocked = blockSource | auto_reclose_running;
    end

    // ------------------------------------------------------------
    // State sequencing
    // ------------------------------------------------------------
    always @* begin
        next_state = state;
        startLoadOff = 1'h0;
        startMax = 1'h0;
        startSettle = 1'h0;
        stopSettle = 1'h0;
        case (state)
            ST_WARM: begin
                if (isCold) begin
                    next_state = ST_LOADOFF;
                    startLoadOff = 1'h1;
                end
            end
            ST_LOADOFF: begin
                if (!isCold) begin
                    next_state = ST_WARM;
                end else if (loadOffDone) begin
                    next_state = ST_COLD;
                end
            end
            ST_COLD: begin
                if (!isCold) begin
                    next_state = ST_INRUSH;
                    startMax = 1'h1;
                end
            end
            ST_INRUSH: begin
                if (maxDone) begin
                    next_state = ST_WARM;
                end else if (settleSeen && belowRelease) begin
                    next_state = ST_HOLD;
                    startSettle = 1'h1;
                end
            end
            ST_HOLD: begin
                if (maxDone) begin
                    next_state = ST_WARM;
                end else if (!belowRelease) begin
                    next_state = ST_INRUSH;
                    stopSettle = 1'h1;
                end else if (settleDone) begin
                    next_state = ST_WARM;
                end
            end
            default: next_state = ST_WARM;
        endcase
    end

    // ------------------------------------------------------------
    // Inrush tracking
    // ------------------------------------------------------------
    always @* begin
        next_settleSeen = settleSeen;
        if (aboveThr) begin
            next_settleSeen = 1'h1;
        end else if (startMax) begin
            next_settleSeen = 1'h0;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            settleSeen <= 1'h0;
        end else if (blocked) begin
            settleSeen <= 1'h0;
        end else begin
            settleSeen <= next_settleSeen;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_WARM;
        end else if (blocked) begin
            state <= ST_WARM;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Output decode
    // ------------------------------------------------------------
    always @* begin
        next_inrush = inWatch && aboveThr;
        // Enable is a level only; nothing here can trip.
        next_enable = (next_state == ST_COLD) ||
            (next_state == ST_INRUSH) || (next_state == ST_HOLD);
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cold_load_enable <= 1'h0;
            inrushPresent <= 1'h0;
            stateOut <= ST_WARM;
        end else if (blocked) begin
            cold_load_enable <= 1'h0;
            inrushPresent <= 1'h0;
            stateOut <= ST_WARM;
        end else begin
            cold_load_enable <= next_enable;
            inrushPresent <= next_inrush;
            stateOut <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Timer control
    // ------------------------------------------------------------
    assign loadOffStop = blocked || ((state == ST_LOADOFF) && !isCold);
    assign settleStop = blocked || stopSettle || !inWatch;
    assign holdRelease = (state == ST_HOLD) && settleDone;
    assign maxStop = blocked || (!inWatch && !startMax) ||
        holdRelease;

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    delay_counter loadOffTimer (
        .clk(clk),
        .rst(rst),
        .start(startLoadOff),
        .stop(loadOffStop),
        .preset(loadOffPreset),
        .running(),
        .done(loadOffDone)
    );

    delay_counter settleTimer (
        .clk(clk),
        .rst(rst),
        .start(startSettle),
        .stop(settleStop),
        .preset(settlePreset),
        .running(),
        .done(settleDone)
    );

    delay_counter maxBlockTimer (
        .clk(clk),
        .rst(rst),
        .start(startMax),
        .stop(maxStop),
        .preset(maxBlockPreset),
        .running(),
        .done(maxDone)
    );
endmodule

// [verif/feeder_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------
// Breaker contact and current sensing model
// ----------------------------------------------
module feeder_model #(parameter [15:0] UC_LEVEL = 16'h0010) (
    input wire clk,
    input wire rst,
    input wire openCmd,
    input wire [15:0] currentCmd,
    output reg breakerOpen,
    output reg [15:0] loadCurrent,
    output wire underCurrent
);
    // The measurement lags the command by one sample.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            breakerOpen <= 1'b1;
            loadCurrent <= 16'h0000;
        end else begin
            breakerOpen <= openCmd;
            loadCurrent <= currentCmd;
        end
    end
    assign underCurrent = loadCurrent < UC_LEVEL;
endmodule

// [verif/cold_load_props.sv]
`timescale 1ns/10ps
// ----------------------------------------------
// Port checker
// ----------------------------------------------
module cold_load_props (
    input wire clk,
    input wire rst,
    input wire [1:0] detectMode,
    input wire breakerOpen,
    input wire underCurrent,
    input wire [15:0] loadCurrent,
    input wire [15:0] inrushThreshold,
    input wire externalBlock,
    input wire internalBlock,
    input wire blockSelect,
    input wire auto_reclose_running,
    input wire cold_load_enable,
    input wire inrushPresent,
    input wire [4:0] stateOut
);
    wire blk = auto_reclose_running |
        (blockSelect ? externalBlock : internalBlock);
    wire m0 = detectMode == 2'h0;
    wire m1 = detectMode == 2'h1;
    wire m2 = detectMode == 2'h2;
    wire cold = m0 ? breakerOpen : m1 ? underCurrent :
        m2 ? (breakerOpen & underCurrent) : (breakerOpen | underCurrent);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence settleEntry;
        $rose(stateOut == 5'h10);
    endsequence
    a_warm_start: assert property (stateOut == 5'h01 && cold && !blk |=>
        stateOut == 5'h02) else $error("load-off not started");
    a_cold_enable: assert property (stateOut == 5'h04 |-> cold_load_enable)
        else $error("enable low in cold state");
    a_enable_src: assert property ($rose(cold_load_enable) |->
        $past(stateOut) == 5'h02) else $error("enable rose off load-off");
    a_cold_ends: assert property (stateOut == 5'h04 && !cold && !blk |=>
        stateOut == 5'h08) else $error("inrush watch not started");
    a_inrush_seen: assert property (stateOut == 5'h08 && !blk &&
        loadCurrent > inrushThreshold |=> inrushPresent || stateOut == 5'h01)
        else $error("inrush not flagged");
    a_settle_entry: assert property (settleEntry |->
        {4'h0, $past(loadCurrent)} * 20'ha <=
        {4'h0, $past(inrushThreshold)} * 20'h9) else $error("early settle");
    a_drop_warm: assert property ($fell(cold_load_enable) |->
        stateOut == 5'h01) else $error("enable fell outside warm");
    a_block_clear: assert property (blk |=> !cold_load_enable &&
        stateOut == 5'h01) else $error("block not honoured");
    a_state_shape: assert property ($onehot(stateOut) &&
        (stateOut[4:2] != 3'h0 || !cold_load_enable)) else $error("bad state");
endmodule

// [verif/cold_load_pickup_detector_tb.sv]
`timescale 1ns/10ps
// ----------------------------------------------
// Testbench
// ----------------------------------------------
module cold_load_pickup_detector_tb;
    reg clk, rst, openCmd, externalBlock, internalBlock, blockSelect;
    reg auto_reclose_running;
    reg [1:0] detectMode;
    reg [15:0] currentCmd;
    wire breakerOpen, underCurrent, cold_load_enable, inrushPresent;
    wire [15:0] loadCurrent;
    wire [4:0] stateOut;
    integer num_errors, n_tests, m, k, cnt;
    feeder_model i_feeder_model (.clk(clk), .rst(rst), .openCmd(openCmd),
        .currentCmd(currentCmd), .breakerOpen(breakerOpen),
        .loadCurrent(loadCurrent), .underCurrent(underCurrent));
    cold_load_pickup_detector i_cold_load_pickup_detector (.clk, .rst,
        .detectMode, .breakerOpen, .underCurrent, .loadCurrent,
        .inrushThreshold(16'h0064), .loadOffPreset(32'h00000005),
        .settlePreset(32'h00000004), .maxBlockPreset(32'h00000028),
        .externalBlock, .internalBlock, .blockSelect,
        .auto_reclose_running, .cold_load_enable, .inrushPresent, .stateOut);
    task print_verdict;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task feed(input o, input [15:0] c, input integer n);
        openCmd = o;
        currentCmd = c;
        repeat (n) @(negedge clk);
    endtask
    task waitEn(input v, input integer lim);
        cnt = 0;
        while (cold_load_enable !== v && cnt < lim) begin
            @(negedge clk);
            cnt = cnt + 1;
        end
        if (cold_load_enable !== v) begin
            num_errors = num_errors + 1;
            $display("wrong value t=%0t got=%h exp=%h", $time,
                cold_load_enable, v);
            print_verdict;
        end
    endtask
    task clr;
        {externalBlock, blockSelect, internalBlock} = 3'h6;
        auto_reclose_running = 0;
        feed(0, 16'h0050, 2);
        chk({cold_load_enable, stateOut}, 6'h01);
        externalBlock = 0;
    endtask
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {rst, openCmd, externalBlock, internalBlock, blockSelect} = 5'h10;
        {auto_reclose_running, detectMode, currentCmd} = 19'h0;
        num_errors = 0;
        n_tests = 0;
        repeat (12) @(negedge clk);
        rst = 0;
        for (m = 0; m < 4; m = m + 1) for (k = 0; k < 4; k = k + 1) begin
            detectMode = m[1:0];
            feed(k[1], k[0] ? 16'h0000 : 16'h0050, 14);
            chk(cold_load_enable, m == 0 ? k[1] : m == 1 ? k[0] :
                m == 2 ? k[1] & k[0] : k[1] | k[0]);
            clr;
        end
        $display("mode test done");
        detectMode = 2'h0;
        feed(1, 16'h0000, 4);
        chk(cold_load_enable, 0);
        waitEn(1, 20);
        feed(0, 16'h00c8, 3);
        chk({inrushPresent, stateOut}, 6'h28);
        feed(0, 16'h005b, 4);
        chk(stateOut, 5'h08);
        feed(0, 16'h005a, 3);
        chk({cold_load_enable, stateOut}, 6'h30);
        feed(0, 16'h00c8, 3);
        chk(stateOut, 5'h08);
        feed(0, 16'h005a, 0);
        waitEn(0, 14);
        chk(cnt > 4, 1);
        $display("settle test done");
        feed(1, 16'h0000, 0);
        waitEn(1, 20);
        feed(0, 16'h00c8, 0);
        waitEn(0, 60);
        chk(cnt >= 40 && cnt <= 46, 1);
        $display("max block test done");
        for (k = 0; k < 3; k = k + 1) begin
            {blockSelect, internalBlock} = {1'b0, k == 0};
            {auto_reclose_running, externalBlock} = {k == 1, k == 2};
            feed(1, 16'h0000, 14);
            chk(cold_load_enable, k == 2);
            clr;
        end
        $display("block test done");
        print_verdict;
    end
endmodule
bind cold_load_pickup_detector cold_load_props i_cold_load_props (.clk,
    .rst, .detectMode, .breakerOpen, .underCurrent, .loadCurrent,
    .inrushThreshold, .externalBlock, .internalBlock, .blockSelect,
    .auto_reclose_running, .cold_load_enable, .inrushPresent, .stateOut);
